// *** core/dcd_pkg.sv ***
// Package: constants and types for the DRAM control and clock divider block
package dcd_pkg;
    // Timing figures
    localparam int DCD_MCLK_MHZ = 100;
    localparam int DCD_RAS_NS = 30;
    localparam int DCD_RAS_CYC = (DCD_RAS_NS * DCD_MCLK_MHZ + 999) / 1000;
    localparam int DCD_CAS_NS = 30;
    localparam int DCD_CAS_CYC = (DCD_CAS_NS * DCD_MCLK_MHZ + 999) / 1000;
    // Division ratios
    localparam int DCD_DIV_HALF = 2;
    localparam int DCD_DIV_CPU = 4;
    localparam int DCD_DIV_SLOW = 32;
    // Reset values of clock outputs (held high while powered off)
    localparam logic DCD_CLK_RST = 1'b1;
    // Idle levels of the synchronised pins, also the mask of the active-low ones
    localparam logic [13:0] DCD_PIN_IDLE = 14'h0f07;
    // Address split
    localparam int DCD_ROW_LSB = 0;
    localparam int DCD_COL_LSB = 8;
    localparam int DCD_ROM_BIT = 15;
    localparam int DCD_REF_BITS = 7;

    typedef enum logic [2:0] {
        DCD_IDLE,
        DCD_ROW,
        DCD_COL,
        DCD_HOLD,
        DCD_REFRESH
    } dcd_state_t;
endpackage : dcd_pkg

// *** core/dcd_clk_if.sv ***
// Interface: clock-divider outputs and input edges shared between the modules
interface dcd_clk_if;
    logic master_edge;
    logic watch_edge;
    logic clk_half;
    logic clk_cpu;
    logic clk_slow;
    logic hold_high;
    modport div (input master_edge, input watch_edge, input hold_high,
                 output clk_half, output clk_cpu, output clk_slow);
    modport top (output master_edge, output watch_edge, output hold_high,
                 input clk_half, input clk_cpu, input clk_slow);
endinterface : dcd_clk_if

// *** core/dcd_clk_div.sv ***
// Clock divider: half and quarter master rate, watch clock by 32
module dcd_clk_div
    import dcd_pkg::*;
#(
    parameter int SLOW_DIV = DCD_DIV_SLOW
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    dcd_clk_if.div bus
);
    logic [1:0] mcnt;
    logic [1:0] next_mcnt;
    logic [$clog2(SLOW_DIV)-1:0] wcnt;
    logic [$clog2(SLOW_DIV)-1:0] next_wcnt;

    always_comb begin
        next_mcnt = mcnt;
        next_wcnt = wcnt;
        if (bus.hold_high) begin
            next_mcnt = '0;
            next_wcnt = '0;
        end else begin
            if (bus.master_edge) begin
                next_mcnt = mcnt + 2'h1;
            end
            if (bus.watch_edge) begin
                next_wcnt = wcnt + 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            mcnt <= '0;
            wcnt <= '0;
        end else begin
            mcnt <= next_mcnt;
            wcnt <= next_wcnt;
        end
    end

    // Counters count from zero, so the MSB is low-active-first; invert to start high
    assign bus.clk_half = ~mcnt[0]; // [RQ1]
    assign bus.clk_cpu = ~mcnt[1]; // [RQ2]
    assign bus.clk_slow = ~wcnt[$clog2(SLOW_DIV)-1]; // [RQ3] [RQ4]
endmodule : dcd_clk_div

// *** core/dcd_top.sv ***
// Top: DRAM control, boot ROM select, interrupt merge, reset and clock division
// Contract
// RQ1: Half-rate clock from master clock output
// RQ2: Processor clock is master clock over four
// RQ3: Slow clock is watch clock over 32
// RQ4: Watch clock input sources the slow clock
// RQ5: Bank select comes from port bit 0
// RQ6: Bank 0 and A15 low selects boot ROM
// RQ7: Power-off resets flops, holds listed outputs high
// RQ8: System reset asserted during power-off
// RQ9: System reset follows sub-processor reset input
// RQ10: Companion interrupt drives processor interrupt low
// RQ11: Standby: write enable from sub-processor
// RQ12: Standby: column strobe from sub-processor
// RQ13: Eight muxed address lines, row/column halves
// RQ14: Processor refresh issues DRAM refresh
// RQ15: Test input held low normally
// RQ16: Refresh address forwarded on low lines
// RQ17: Row strobe before column half and strobe
// RQ18: Memory read only with request and read
module dcd_top
    import dcd_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int MUX_W = 8,
    parameter int SLOW_DIV = DCD_DIV_SLOW
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Clock pins
    input wire logic i_master_clk,
    input wire logic i_watch_crystal_in,
    output logic o_clk_half,
    output logic o_cpu_clock_out,
    output logic o_slow_clock_out,
    // Processor bus (active low strobes)
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_mreq_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic i_m1_n,
    input wire logic i_halt_n,
    input wire logic i_cpu_refresh_in_n,
    input wire logic i_bank_sel,
    input wire logic i_option_ram_select_n,
    // Sub-processor and system
    input wire logic i_power_off,
    input wire logic i_sub_reset,
    input wire logic i_standby_write_ctl,
    input wire logic i_standby_col_strobe_ctl,
    input wire logic i_companion_int_n,
    input wire logic i_test,
    // DRAM side
    output logic [MUX_W-1:0] o_dram_mux_addr,
    output logic o_dram_row_strobe_n,
    output logic o_dram_col_strobe_n,
    output logic o_dram_write_enable_n,
    output logic o_dram_refresh_out_n,
    output logic o_memory_read_strobe_n,
    output logic o_boot_rom_select_n,
    output logic o_cpu_int_n,
    output logic o_system_reset_out_n
);
    // Three-stage synchronisers for all pin inputs except the unused i_m1_n and i_test
    localparam int SW = 14;
    logic [SW-1:0] pin_raw, s1, s2, s3, pin, next_pin;
    logic [ADDR_W-1:0] a1, a2, a3, addr, next_addr;

    assign pin_raw = {i_master_clk, i_watch_crystal_in, i_mreq_n, i_rd_n, i_wr_n,
                      i_cpu_refresh_in_n, i_bank_sel, i_power_off, i_sub_reset,
                      i_standby_write_ctl, i_standby_col_strobe_ctl, i_companion_int_n,
                      i_halt_n, i_option_ram_select_n};

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            s1 <= DCD_PIN_IDLE; // Idle levels, so no false request follows reset
            s2 <= DCD_PIN_IDLE;
            s3 <= DCD_PIN_IDLE;
            pin <= DCD_PIN_IDLE;
            a1 <= '0;
            a2 <= '0;
            a3 <= '0;
            addr <= '0;
        end else begin
            s1 <= pin_raw;
            s2 <= s1;
            s3 <= s2;
            // A change counts once the second and third stages agree
            pin <= next_pin;
            a1 <= i_addr;
            a2 <= a1;
            a3 <= a2;
            addr <= next_addr;
        end
    end

    genvar g;
    generate
        for (g = 0; g < SW; g++) begin : g_pin
            assign next_pin[g] = (s2[g] == s3[g]) ? s3[g] : pin[g];
        end
        for (g = 0; g < ADDR_W; g++) begin : g_adr
            assign next_addr[g] = (a2[g] == a3[g]) ? a3[g] : addr[g];
        end
    endgenerate

    logic master_q, watch_q, mreq, rd, wr, rfsh, bank1, off;
    logic sub_rst, sb_we, sb_cas, cint, standby, opt_sel;
    // Active-low pins are inverted by the same mask that gives their idle levels
    assign {master_q, watch_q, mreq, rd, wr, rfsh, bank1, off, sub_rst, sb_we, sb_cas, cint,
            standby, opt_sel} = pin ^ DCD_PIN_IDLE;

    // Edge detection on the filtered clock pins
    logic master_prev, watch_prev;
    dcd_clk_if cif ();
    assign cif.master_edge = master_q & ~master_prev;
    assign cif.watch_edge = watch_q & ~watch_prev;
    assign cif.hold_high = off; // [RQ7]

    dcd_clk_div #(.SLOW_DIV(SLOW_DIV)) u_div (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .bus(cif)
    );

    // Access sequencer; test input is assumed low and otherwise unused [RQ15]
    dcd_state_t state, next_state;
    logic [1:0] cnt, next_cnt;
    logic rom_hit, ram_req;
    // Bank level comes straight from the port bit written by the processor [RQ5]
    assign rom_hit = ~bank1 & ~addr[DCD_ROM_BIT]; // [RQ6]
    assign ram_req = mreq & (rd | wr) & ~rom_hit & ~opt_sel;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            DCD_IDLE: begin
                next_cnt = '0;
                if (mreq & rfsh) begin
                    next_state = DCD_REFRESH; // [RQ14]
                end else if (ram_req) begin
                    next_state = DCD_ROW; // [RQ17]
                end
            end
            DCD_ROW: begin
                next_cnt = cnt + 2'h1;
                if (32'(cnt) + 1 >= DCD_RAS_CYC) begin
                    next_state = DCD_COL;
                    next_cnt = '0;
                end
            end
            DCD_COL: begin
                next_cnt = cnt + 2'h1;
                if (32'(cnt) + 1 >= DCD_CAS_CYC) begin
                    next_state = DCD_HOLD;
                end
            end
            DCD_HOLD: begin
                if (!mreq) begin
                    next_state = DCD_IDLE;
                end
            end
            DCD_REFRESH: begin
                if (!(mreq & rfsh)) begin
                    next_state = DCD_IDLE;
                end
            end
            default: begin
                next_state = DCD_IDLE;
            end
        endcase
        if (off) begin
            next_state = DCD_IDLE;
            next_cnt = '0;
        end
    end

    // Registered outputs
    logic [MUX_W-1:0] next_mux;
    logic next_ras_n, next_cas_n, next_we_n, next_ref_n, next_mr_n, next_rom_n, next_int_n, next_rst_n;

    always_comb begin
        next_mux = addr[DCD_ROW_LSB +: MUX_W]; // [RQ13]
        if (state == DCD_COL || state == DCD_HOLD) begin
            next_mux = addr[DCD_COL_LSB +: MUX_W]; // [RQ13]
        end
        if (state == DCD_REFRESH) begin
            // Refresh row count sits on the low seven lines only [RQ16]
            next_mux = {{(MUX_W - DCD_REF_BITS){1'b0}}, addr[DCD_REF_BITS-1:0]};
        end
        next_ras_n = ~(state == DCD_ROW || state == DCD_COL || state == DCD_HOLD
                       || state == DCD_REFRESH); // [RQ17]
        next_cas_n = ~(state == DCD_COL || state == DCD_HOLD);
        next_we_n = ~(wr & (state == DCD_COL || state == DCD_HOLD));
        if (standby) begin
            next_we_n = ~sb_we; // [RQ11]
            next_cas_n = ~sb_cas; // [RQ12]
        end
        next_ref_n = ~(state == DCD_REFRESH); // [RQ14]
        next_mr_n = ~(mreq & rd); // [RQ18]
        next_rom_n = ~(mreq & rom_hit); // [RQ6]
        next_int_n = ~cint; // [RQ10]
        next_rst_n = ~(sub_rst | off); // [RQ8] [RQ9]
        if (off) begin
            // Power-off parks the DRAM side inactive, listed outputs high [RQ7]
            next_mux = '0;
            next_ras_n = 1'b1;
            next_cas_n = 1'b1;
            next_we_n = 1'b1;
            next_ref_n = 1'b1;
            next_mr_n = 1'b1;
            next_rom_n = 1'b1;
            next_int_n = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state <= DCD_IDLE;
            cnt <= '0;
            master_prev <= 1'b0;
            watch_prev <= 1'b0;
            o_dram_mux_addr <= '0;
            o_dram_row_strobe_n <= 1'b1;
            o_dram_col_strobe_n <= 1'b1;
            o_dram_write_enable_n <= 1'b1;
            o_dram_refresh_out_n <= 1'b1;
            o_memory_read_strobe_n <= 1'b1;
            o_boot_rom_select_n <= 1'b1;
            o_cpu_int_n <= 1'b1;
            o_system_reset_out_n <= 1'b0;
            o_clk_half <= DCD_CLK_RST;
            o_cpu_clock_out <= DCD_CLK_RST;
            o_slow_clock_out <= DCD_CLK_RST;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            master_prev <= master_q;
            watch_prev <= watch_q;
            o_dram_mux_addr <= next_mux;
            o_dram_row_strobe_n <= next_ras_n;
            o_dram_col_strobe_n <= next_cas_n;
            o_dram_write_enable_n <= next_we_n;
            o_dram_refresh_out_n <= next_ref_n;
            o_memory_read_strobe_n <= next_mr_n;
            o_boot_rom_select_n <= next_rom_n;
            o_cpu_int_n <= next_int_n;
            o_system_reset_out_n <= next_rst_n;
            o_clk_half <= cif.clk_half; // [RQ1]
            o_cpu_clock_out <= cif.clk_cpu; // [RQ2]
            o_slow_clock_out <= cif.clk_slow; // [RQ3]
        end
    end

    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    logic [1:0] off_age;
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || !off) begin
            off_age <= '0;
        end else if (off_age != 2'h3) begin
            off_age <= off_age + 2'h1;
        end
    end

    off_hold_a: assert property (off_age == 2'h3 |-> o_cpu_clock_out && o_clk_half
        && o_slow_clock_out && o_boot_rom_select_n && o_cpu_int_n
        && o_memory_read_strobe_n && o_dram_row_strobe_n)
        else $error("power-off outputs not parked"); // [RQ7]
    sys_reset_a: assert property ((off | sub_rst) |=> !o_system_reset_out_n)
        else $error("system reset not asserted"); // [RQ8] [RQ9]
    int_merge_a: assert property (cint && !off |=> !o_cpu_int_n)
        else $error("interrupt not forwarded"); // [RQ10]
    sb_we_a: assert property (standby && !off |=> o_dram_write_enable_n == !$past(sb_we))
        else $error("standby write enable wrong"); // [RQ11]
    sb_cas_a: assert property (standby && !off |=> o_dram_col_strobe_n == !$past(sb_cas))
        else $error("standby column strobe wrong"); // [RQ12]
    rom_sel_a: assert property (mreq && rom_hit && !off |=> !o_boot_rom_select_n)
        else $error("boot ROM not selected"); // [RQ6]
    mem_rd_a: assert property (!o_memory_read_strobe_n |-> $past(mreq && rd))
        else $error("read strobe without request"); // [RQ18]
    ras_first_a: assert property (state == DCD_IDLE && next_state == DCD_ROW && !standby
        |=> ##1 !o_dram_row_strobe_n && o_dram_col_strobe_n)
        else $error("row strobe not first"); // [RQ17]
    refresh_a: assert property (state == DCD_REFRESH && !off |=> !o_dram_refresh_out_n)
        else $error("refresh not issued"); // [RQ14]
    cpu_div_a: assert property ($rose(cif.clk_cpu) && !$past(off)
        |-> $past(cif.clk_half, 1) == 1'b0)
        else $error("processor clock phase wrong"); // [RQ2]

    cv_ram: cover property (state == DCD_ROW ##[1:4] state == DCD_HOLD);
    cv_ref: cover property (state == DCD_REFRESH);
    cv_rom: cover property (!o_boot_rom_select_n);
    cv_sb: cover property (standby && sb_cas);
endmodule : dcd_top

// *** tb/dcd_cpu_model.sv ***
// Processor bus model that runs memory read, write and refresh cycles
module dcd_cpu_model (
    // Commands from the bench
    input wire logic i_mclk,
    input wire logic i_go,
    input wire logic [1:0] i_kind,
    input wire logic [15:0] i_adr,
    input wire logic [3:0] i_slow,
    // Answers from the block
    input wire logic i_cas_n,
    input wire logic i_ref_n,
    // Processor bus
    output logic [15:0] o_addr,
    output logic o_mreq_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic o_rfsh_n,
    output logic o_done
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        int n;
        o_addr = 16'h0000;
        {o_mreq_n, o_rd_n, o_wr_n, o_rfsh_n, o_done} = 5'h1e;
        forever begin
            @(posedge i_mclk);
            o_done <= 1'b0;
            if (i_go) begin
                o_addr <= i_adr;
                o_mreq_n <= 1'b0;
                o_rd_n <= (i_kind != 2'd0);
                o_wr_n <= (i_kind != 2'd1);
                o_rfsh_n <= (i_kind != 2'd2);
                // A boot ROM cycle never answers, so the wait is bounded
                for (n = 0; n < 80 && (i_kind == 2'd2 ? i_ref_n : i_cas_n); n++) begin
                    @(posedge i_mclk);
                end
                repeat (i_slow) @(posedge i_mclk);
                // Released lines float, so show a value unlike the last one
                o_addr <= ~i_adr;
                {o_mreq_n, o_rd_n, o_wr_n, o_rfsh_n} <= 4'hf;
                o_done <= 1'b1;
            end
        end
    end
endmodule // dcd_cpu_model

// *** tb/dcd_top_bench.sv ***
// Self-checking bench for the DRAM control and clock divider top
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module dcd_top_bench;
    import dcd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SDIV = 4;
    logic i_mclk, i_rst_n, i_master_clk, i_watch_crystal_in;
    logic o_clk_half, o_cpu_clock_out, o_slow_clock_out;
    logic [15:0] addr, adr;
    logic mreq_n, rd_n, wr_n, rfsh_n, done, go, sb, rf, bank, opt_n;
    logic [1:0] kind;
    logic [3:0] slow;
    logic pwr, sub_rst, sb_we, sb_cas, cint_n;
    logic [7:0] o_dram_mux_addr;
    logic o_dram_row_strobe_n, o_dram_col_strobe_n, o_dram_write_enable_n;
    logic o_dram_refresh_out_n, o_memory_read_strobe_n, o_boot_rom_select_n;
    logic o_cpu_int_n, o_system_reset_out_n, ras_q, cas_q, ref_q;
    logic [9:0] expq[$];
    logic [9:0] note;
    int err_total = 0;
    int n_compared = 0;
    int seed = 32'hf2ea;
    dcd_top #(.SLOW_DIV(SDIV)) uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_master_clk(i_master_clk), .i_watch_crystal_in(i_watch_crystal_in),
        .o_clk_half(o_clk_half), .o_cpu_clock_out(o_cpu_clock_out),
        .o_slow_clock_out(o_slow_clock_out), .i_addr(addr), .i_mreq_n(mreq_n),
        .i_rd_n(rd_n), .i_wr_n(wr_n), .i_m1_n(1'b1), .i_halt_n(!sb),
        .i_cpu_refresh_in_n(rfsh_n), .i_bank_sel(bank), .i_option_ram_select_n(opt_n),
        .i_power_off(pwr), .i_sub_reset(sub_rst), .i_standby_write_ctl(sb_we),
        .i_standby_col_strobe_ctl(sb_cas), .i_companion_int_n(cint_n), .i_test(1'b0),
        .o_dram_mux_addr(o_dram_mux_addr), .o_dram_row_strobe_n(o_dram_row_strobe_n),
        .o_dram_col_strobe_n(o_dram_col_strobe_n),
        .o_dram_write_enable_n(o_dram_write_enable_n),
        .o_dram_refresh_out_n(o_dram_refresh_out_n),
        .o_memory_read_strobe_n(o_memory_read_strobe_n),
        .o_boot_rom_select_n(o_boot_rom_select_n), .o_cpu_int_n(o_cpu_int_n),
        .o_system_reset_out_n(o_system_reset_out_n));
    dcd_cpu_model cpu (.i_mclk(i_mclk), .i_go(go), .i_kind(kind), .i_adr(adr),
        .i_slow(slow), .i_cas_n(o_dram_col_strobe_n), .i_ref_n(o_dram_refresh_out_n),
        .o_addr(addr), .o_mreq_n(mreq_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
        .o_rfsh_n(rfsh_n), .o_done(done));
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // Pins slow enough for the three-stage synchronisers
    initial begin
        i_master_clk = 1'b0;
        #3;
        forever #100 i_master_clk = ~i_master_clk;
    end
    initial begin
        i_watch_crystal_in = 1'b0;
        #7;
        forever #200 i_watch_crystal_in = ~i_watch_crystal_in;
    end
    function automatic logic [9:0] nxt();
        if (expq.size() > 0) begin
            return expq.pop_front();
        end
        return 10'bx;
    endfunction
    // Outside standby each strobe fall takes the oldest note, except row and column falls in a refresh; an unplanned access finds none
    always @(posedge i_mclk) begin
        ras_q <= o_dram_row_strobe_n;
        cas_q <= o_dram_col_strobe_n;
        ref_q <= o_dram_refresh_out_n;
        // Take each note once, so a mismatch report cannot swallow the next note
        if (sb !== 1'b1 && ref_q === 1'b1 && o_dram_refresh_out_n === 1'b0) begin
            note = nxt();
            `CHK({2'b00, o_dram_mux_addr}, note)
        end
        if (sb !== 1'b1 && rf !== 1'b1 && ras_q === 1'b1 && o_dram_row_strobe_n === 1'b0) begin
            note = nxt();
            `CHK({2'b00, o_dram_mux_addr}, note)
        end
        if (sb !== 1'b1 && rf !== 1'b1 && cas_q === 1'b1 && o_dram_col_strobe_n === 1'b0) begin
            note = nxt();
            `CHK({o_dram_write_enable_n, o_memory_read_strobe_n, o_dram_mux_addr},
                 note)
        end
    end
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic acc(input logic [1:0] k, input logic [15:0] a, input bit rom);
        int n;
        @(negedge i_mclk);
        rf = (k == 2'd2);
        if (rf) begin
            expq.push_back({3'b000, a[6:0]});
        end else if (!rom && opt_n) begin
            expq.push_back({2'b00, a[7:0]});
            expq.push_back({k != 2'd1, k != 2'd0, a[15:8]});
        end
        go = 1'b1;
        kind = k;
        adr = a;
        slow = 4'($unsigned($random(seed)));
        @(negedge i_mclk);
        go = 1'b0;
        for (n = 0; n < 200 && done !== 1'b1; n++) @(negedge i_mclk);
        if (done !== 1'b1) begin
            err_total++;
            results();
        end
        `CHK(o_boot_rom_select_n, !rom)
        repeat (10) @(negedge i_mclk);
        `CHK(expq.size(), 0)
        rf = 1'b0;
    endtask
    task automatic per(ref logic c, input int exp);
        int n, k;
        n = 0;
        for (k = 0; k < 4; k++) begin
            if (k == 2) n = 0;
            while (c !== k[0] && n < 3000) begin
                @(posedge i_mclk);
                n++;
            end
        end
        `CHK(n, exp)
    endtask
    task automatic lvl(input logic [4:0] exp);
        repeat (12) @(negedge i_mclk);
        `CHK({o_cpu_int_n, o_system_reset_out_n, o_dram_write_enable_n,
              o_dram_col_strobe_n, o_boot_rom_select_n}, exp)
    endtask
    initial begin
        {i_rst_n, go, sb, rf, pwr, sub_rst, sb_we, sb_cas} = 8'h00;
        {bank, opt_n, cint_n} = 3'b111;
        {kind, adr, slow} = 22'h0;
        repeat (4) @(negedge i_mclk);
        i_rst_n = 1'b1;
        repeat (8) @(negedge i_mclk);
        per(o_clk_half, 2 * 20);
        per(o_cpu_clock_out, 4 * 20);
        per(o_slow_clock_out, SDIV * 40);
        $display("clock division done");
        acc(2'd0, 16'h1234, 1'b0);
        acc(2'd1, 16'hfe01, 1'b0);
        acc(2'd2, 16'hff7f, 1'b0);
        bank = 1'b0;
        acc(2'd0, 16'h7f00, 1'b1);
        acc(2'd0, 16'h8001, 1'b0);
        bank = 1'b1;
        acc(2'd1, 16'h0100, 1'b0);
        // Option unit claims the cycle: no DRAM strobes may follow
        opt_n = 1'b0;
        acc(2'd0, 16'h8123, 1'b0);
        opt_n = 1'b1;
        for (int i = 0; i < 12; i++) begin
            acc(2'($unsigned($random(seed)) % 3), 16'($random(seed)) | 16'h8000, 1'b0);
        end
        $display("dram cycles done");
        cint_n = 1'b0;
        lvl(5'b01111);
        sub_rst = 1'b1;
        lvl(5'b00111);
        cint_n = 1'b1;
        sub_rst = 1'b0;
        sb = 1'b1;
        sb_we = 1'b1;
        lvl(5'b11011);
        sb_we = 1'b0;
        sb_cas = 1'b1;
        lvl(5'b11101);
        sb_cas = 1'b0;
        lvl(5'b11111);
        sb = 1'b0;
        $display("levels done");
        pwr = 1'b1;
        cint_n = 1'b0;
        bank = 1'b0;
        repeat (12) @(negedge i_mclk);
        for (int i = 0; i < 6; i++) begin
            repeat (20) @(negedge i_mclk);
            `CHK({o_clk_half, o_cpu_clock_out, o_boot_rom_select_n,
                  o_memory_read_strobe_n, o_cpu_int_n, o_system_reset_out_n}, 6'h3e)
        end
        $display("power off done");
        results();
    end
endmodule // dcd_top_bench
